// ### rtl/oar_pkg.sv
// How it works
// RQ1: OR-immediate ORs immediate into accumulator and updates zero.
// RQ2: OR-into-memory writes accumulator OR memory byte back; updates zero.
// RQ3: Subroutine return pops stack into program counter, flags unchanged.
// RQ4: Immediate return pops PC and loads immediate into accumulator.
// RQ5: Return-from-interrupt pops PC and sets global interrupt enable.
// RQ6: Interrupt pending at return-from-interrupt is served first.
// RQ7: Zero flag set when OR result is zero, cleared otherwise; others kept.
package oar_pkg;
  localparam int PC_W    = 13;
  localparam int ADDR_W  = 8;
  localparam int STACK_D = 8;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef enum logic [2:0] {
    OAR_NOP, OAR_OR_IMM, OAR_OR_MEM, OAR_RET, OAR_RET_IMM, OAR_RETURN_FROM_INTERRUPT_INSTR
  } oar_op_t;

  // One decoded instruction from the fetch stage
  typedef struct packed {
    logic              valid;
    oar_op_t           op;
    logic [7:0]        imm;
    logic [ADDR_W-1:0] addr;
  } oar_instr_t;

  // Data memory write request
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } oar_mem_wr_t;
endpackage

// ### rtl/oar_core.sv
`timescale 1ns/1ps
module oar_core
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  oar_pkg::oar_instr_t        instr,
  input  wire logic [7:0]            mem_rdata,
  output logic [oar_pkg::ADDR_W-1:0] mem_raddr,
  output oar_pkg::oar_mem_wr_t       mem_wr,
  input  wire logic                  call_valid,
  input  wire logic [oar_pkg::PC_W-1:0] call_ret_pc,
  input  wire logic                  irq_pending,
  input  wire logic                  gie_clear,
  output logic [oar_pkg::PC_W-1:0]   pc,
  output logic                       pc_load,
  output logic [7:0]                 accumulator,
  output logic                       zero_flag,
  output logic                       global_interrupt_enable,
  output logic                       irq_taken
);
  import oar_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            pc_load;
    logic [7:0]      acc;
    logic            z;
    logic            gie;
    logic            irq_taken;
    oar_mem_wr_t     wr;
    logic [2:0]      sp;
  } oar_state_t;

  oar_state_t s;
  oar_state_t next_s;
  logic [PC_W-1:0] stack [STACK_D];
  logic [7:0] or_res;
  logic is_ret;
  logic [2:0] top;

  // Zero test used by both OR forms
  function automatic logic oar_is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  assign mem_raddr = instr.addr;
  assign top = s.sp - 3'd1;
  assign is_ret = instr.valid && (instr.op == OAR_RET ||
                  instr.op == OAR_RET_IMM || instr.op == OAR_RETURN_FROM_INTERRUPT_INSTR);
  assign or_res = s.acc | ((instr.op == OAR_OR_MEM) ? mem_rdata : instr.imm);

  // Next-state decode
  always_comb begin
    next_s = s;
    next_s.pc_load = 1'b0;
    next_s.irq_taken = 1'b0;
    next_s.wr.we = 1'b0;
    if (gie_clear) begin
      next_s.gie = 1'b0;
    end
    if (call_valid) begin
      next_s.sp = s.sp + 3'd1;
    end
    if (instr.valid) begin
      case (instr.op)
        OAR_OR_IMM: begin
          // RQ1 OR into accumulator
          next_s.acc = or_res;
          // RQ7 zero flag update
          next_s.z = oar_is_zero(or_res);
        end
        OAR_OR_MEM: begin
          // RQ2 OR back to memory
          next_s.wr = '{we: 1'b1, addr: instr.addr, data: or_res};
          // RQ7 zero flag update
          next_s.z = oar_is_zero(or_res);
        end
        OAR_RET: begin
          // RQ3 pop return address
          next_s.pc = stack[top];
          next_s.pc_load = 1'b1;
          next_s.sp = top;
        end
        OAR_RET_IMM: begin
          // RQ4 pop and load immediate
          next_s.pc = stack[top];
          next_s.pc_load = 1'b1;
          next_s.sp = top;
          next_s.acc = instr.imm;
        end
        OAR_RETURN_FROM_INTERRUPT_INSTR: begin
          // RQ5 pop and enable interrupts
          next_s.pc = stack[top];
          next_s.pc_load = 1'b1;
          next_s.sp = top;
          next_s.gie = 1'b1;
          // RQ6 pending interrupt goes first
          if (irq_pending) begin
            next_s.pc = IRQ_VECTOR;
            next_s.gie = 1'b0;
            next_s.irq_taken = 1'b1;
            next_s.sp = s.sp;
          end
        end
        default: begin
          next_s.pc = s.pc;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.acc <= ACC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Return stack; RETURN_FROM_INTERRUPT_INSTR with pending irq keeps the popped address
  always_ff @(posedge clk) begin
    if (call_valid) begin
      stack[s.sp] <= call_ret_pc;
    end
  end

  assign pc = s.pc;
  assign pc_load = s.pc_load;
  assign accumulator = s.acc;
  assign zero_flag = s.z;
  assign global_interrupt_enable = s.gie;
  assign irq_taken = s.irq_taken;
  assign mem_wr = s.wr;

  // RQ1 accumulator result
  property p_or_imm;
    @(posedge clk) disable iff (rst)
    instr.valid && instr.op == OAR_OR_IMM |=> accumulator == $past(or_res);
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or imm wrong"); // RQ1

  // RQ2 memory write
  property p_or_mem;
    @(posedge clk) disable iff (rst)
    instr.valid && instr.op == OAR_OR_MEM |=> mem_wr.we &&
      mem_wr.addr == $past(instr.addr) &&
      mem_wr.data == $past(or_res) && accumulator == $past(accumulator);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or mem wrong"); // RQ2

  // RQ3 return keeps flags
  property p_ret;
    @(posedge clk) disable iff (rst)
    instr.valid && instr.op == OAR_RET |=> pc_load &&
      $stable(zero_flag) && $stable(accumulator);
  endproperty
  a_ret: assert property (p_ret) else $error("ret wrong"); // RQ3

  // RQ4 immediate loaded
  property p_ret_imm;
    @(posedge clk) disable iff (rst)
    instr.valid && instr.op == OAR_RET_IMM |=> pc_load &&
      accumulator == $past(instr.imm) && $stable(zero_flag);
  endproperty
  a_ret_imm: assert property (p_ret_imm) else $error("ret imm wrong"); // RQ4

  // RQ5 enable set
  property p_return_from_interrupt_instr;
    @(posedge clk) disable iff (rst)
    instr.valid && instr.op == OAR_RETURN_FROM_INTERRUPT_INSTR && !irq_pending |=>
      pc_load && global_interrupt_enable && $stable(zero_flag);
  endproperty
  a_return_from_interrupt_instr: assert property (p_return_from_interrupt_instr) else $error("return_from_interrupt_instr wrong"); // RQ5

  // RQ6 pending request at the return
  sequence s_return_from_interrupt_instr_irq;
    instr.valid && instr.op == OAR_RETURN_FROM_INTERRUPT_INSTR && irq_pending;
  endsequence

  // RQ6 vector loaded, enable held off, pulse raised
  sequence s_vector_taken;
    irq_taken && pc_load && pc == IRQ_VECTOR && !global_interrupt_enable;
  endsequence

  // RQ6 interrupt first
  property p_return_from_interrupt_instr_irq;
    @(posedge clk) disable iff (rst)
    s_return_from_interrupt_instr_irq |=> s_vector_taken;
  endproperty
  a_return_from_interrupt_instr_irq: assert property (p_return_from_interrupt_instr_irq) else $error("irq lost"); // RQ6

  // RQ7 zero flag
  property p_zero;
    @(posedge clk) disable iff (rst)
    instr.valid && (instr.op == OAR_OR_IMM || instr.op == OAR_OR_MEM)
      |=> zero_flag == ($past(or_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero wrong"); // RQ7

  // RQ7 non-OR keeps zero
  property p_zero_hold;
    @(posedge clk) disable iff (rst)
    !(instr.valid && (instr.op == OAR_OR_IMM || instr.op == OAR_OR_MEM))
      |=> $stable(zero_flag);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("z moved"); // RQ7

  // RQ3 every return loads the program counter
  property p_ret_load;
    @(posedge clk) disable iff (rst)
    is_ret |=> pc_load;
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("no pc load"); // RQ3

  // RQ2 memory written only by OR-into-memory
  property p_mem_quiet;
    @(posedge clk) disable iff (rst)
    !(instr.valid && instr.op == OAR_OR_MEM) |=> !mem_wr.we;
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("bad write"); // RQ2

  // RQ6 vector pulse only for a serviced request
  property p_irq_only;
    @(posedge clk) disable iff (rst)
    !(instr.valid && instr.op == OAR_RETURN_FROM_INTERRUPT_INSTR && irq_pending) |=> !irq_taken;
  endproperty
  a_irq_only: assert property (p_irq_only) else $error("stray irq"); // RQ6
endmodule

// ### verification/or_and_return_instructions_test.sv
`timescale 1ns/1ps
module or_and_return_instructions_test;
  import oar_pkg::*;
  logic              clk         = 1'b0;
  logic              rst         = 1'b1;
  oar_instr_t        instr       = '0;
  logic              call_valid  = 1'b0;
  logic [PC_W-1:0]   call_ret_pc = '0;
  logic              irq_pending = 1'b0;
  logic              gie_clear   = 1'b0;
  logic [7:0]        mem_rdata;
  logic [ADDR_W-1:0] mem_raddr;
  oar_mem_wr_t       mem_wr;
  logic [PC_W-1:0]   pc;
  logic              pc_load;
  logic [7:0]        accumulator;
  logic              zero_flag;
  logic              gie;
  logic              irq_taken;
  int                n_errors    = 0;
  int                num_checks  = 0;

  // Clock and a data memory whose byte depends on the address
  initial forever #2 clk = ~clk;
  assign mem_rdata = mem_raddr ^ 8'h5a;

  oar_core u_oar_core (.clk(clk), .rst(rst), .instr(instr),
    .mem_rdata(mem_rdata), .mem_raddr(mem_raddr), .mem_wr(mem_wr),
    .call_valid(call_valid), .call_ret_pc(call_ret_pc),
    .irq_pending(irq_pending), .gie_clear(gie_clear), .pc(pc),
    .pc_load(pc_load), .accumulator(accumulator), .zero_flag(zero_flag),
    .global_interrupt_enable(gie), .irq_taken(irq_taken));

  // Compare one value and count it
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One instruction for one cycle, outputs looked at after the answer
  task automatic run(oar_op_t op, logic [7:0] imm, logic [7:0] addr);
    @(posedge clk);
    instr <= '{1'b1, op, imm, addr};
    @(posedge clk);
    instr <= '0;
    #1;
  endtask

  // Push a return address as a call would
  task automatic push(logic [PC_W-1:0] ret);
    @(posedge clk);
    call_valid  <= 1'b1;
    call_ret_pc <= ret;
    @(posedge clk);
    call_valid  <= 1'b0;
  endtask

  task automatic t_or;
    run(OAR_OR_IMM, 8'h00, 8'h00);
    check("acc", accumulator, 8'h00);
    check("zero", zero_flag, 1'b1);
    run(OAR_OR_MEM, 8'h00, 8'h5a);
    check("wdata", mem_wr.data, 8'h00);
    check("zero", zero_flag, 1'b1);
    run(OAR_NOP, 8'hff, 8'h00);
    check("nop acc", accumulator, 8'h00);
    check("nop we", mem_wr.we, 1'b0);
    check("nop zero", zero_flag, 1'b1);
    run(OAR_OR_IMM, 8'h30, 8'h00);
    run(OAR_OR_IMM, 8'h05, 8'h00);
    check("acc", accumulator, 8'h35);
    check("zero", zero_flag, 1'b0);
    run(OAR_OR_MEM, 8'h00, 8'h0f);
    check("we", mem_wr.we, 1'b1);
    check("waddr", mem_wr.addr, 8'h0f);
    check("wdata", mem_wr.data, 8'h75);
    check("acc kept", accumulator, 8'h35);
    check("zero", zero_flag, 1'b0);
    $display("test or done");
  endtask

  task automatic t_ret;
    push(13'h0123);
    push(13'h0456);
    run(OAR_RET, 8'h00, 8'h00);
    check("pc_load", pc_load, 1'b1);
    check("pc", pc, 13'h0456);
    check("acc kept", accumulator, 8'h35);
    check("zero kept", zero_flag, 1'b0);
    run(OAR_RET_IMM, 8'h5c, 8'h00);
    check("pc_load", pc_load, 1'b1);
    check("pc", pc, 13'h0123);
    check("acc", accumulator, 8'h5c);
    check("zero kept", zero_flag, 1'b0);
    $display("test ret done");
  endtask

  task automatic t_return_from_interrupt_instr;
    push(13'h0abc);
    run(OAR_RETURN_FROM_INTERRUPT_INSTR, 8'h00, 8'h00);
    check("pc", pc, 13'h0abc);
    check("gie", gie, 1'b1);
    check("irq", irq_taken, 1'b0);
    check("zero kept", zero_flag, 1'b0);
    @(posedge clk);
    gie_clear <= 1'b1;
    @(posedge clk);
    gie_clear <= 1'b0;
    push(13'h0777);
    irq_pending <= 1'b1;
    run(OAR_RETURN_FROM_INTERRUPT_INSTR, 8'h00, 8'h00);
    check("vector", pc, IRQ_VECTOR);
    check("irq", irq_taken, 1'b1);
    check("gie", gie, 1'b0);
    @(posedge clk);
    irq_pending <= 1'b0;
    run(OAR_RETURN_FROM_INTERRUPT_INSTR, 8'h00, 8'h00);
    check("resume", pc, 13'h0777);
    check("gie", gie, 1'b1);
    check("irq", irq_taken, 1'b0);
    $display("test return_from_interrupt_instr done");
  endtask

  // Counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_or();
    t_ret();
    t_return_from_interrupt_instr();
    complete_run();
  end
endmodule
